// ==== logic/sehy_defs.vh ====
// constants shared by the status event hierarchy design files
// assumes inclusion by bare name from files under logic/
`ifndef SEHY_DEFS_VH
`define SEHY_DEFS_VH

// ------------------------------------------------------------------
// widths and bit positions
// ------------------------------------------------------------------
`define SEHY_W          16
`define SEHY_MSB        15
`define SEHY_VALID      16'h7FFF
`define SEHY_ZERO16     16'h0000
`define SEHY_STB_W      8
`define SEHY_ZERO8      8'h00

// ------------------------------------------------------------------
// part selectors inside one status register group
// ------------------------------------------------------------------
`define SEHY_PART_COND  3'h0
`define SEHY_PART_RISE  3'h1
`define SEHY_PART_FALL  3'h2
`define SEHY_PART_EVT   3'h3
`define SEHY_PART_MASK  3'h4

// ------------------------------------------------------------------
// command targets
// ------------------------------------------------------------------
`define SEHY_TGT_OPER   4'h0
`define SEHY_TGT_QUES   4'h1
`define SEHY_TGT_DEV    4'h2
`define SEHY_TGT_SEVT   4'h3
`define SEHY_TGT_STB    4'h4
`define SEHY_TGT_SRQM   4'h5
`define SEHY_TGT_CLS    4'h6

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SEHY_RISE_RST   16'h7FFF
`define SEHY_FALL_RST   16'h0000
`define SEHY_MASK_RST   16'h0000
`define SEHY_SRQM_RST   8'h00
`define SEHY_SEVM_RST   8'h00

// ------------------------------------------------------------------
// summary status byte bit positions
// ------------------------------------------------------------------
`define SEHY_STB_UNUSED 0
`define SEHY_STB_DEV    1
`define SEHY_STB_ERRQ   2
`define SEHY_STB_QUES   3
`define SEHY_STB_MAV    4
`define SEHY_STB_ESB    5
`define SEHY_STB_MSS    6
`define SEHY_STB_OPER   7
`define SEHY_SRQM_KEEP  8'hBF

`endif

// ==== logic/sehy_group.v ====
// one five-part status register group with transition filters
// assumes command strobes are single-cycle and synchronous to sys_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "sehy_defs.vh"

module sehy_group (
  input  wire        sys_clk_i, // system clock
  input  wire        arst_n_i,  // async reset, active low
  input  wire [14:0] cond_i,    // live hardware conditions
  input  wire        wr_i,      // write strobe for this group
  input  wire        rd_i,      // read strobe for this group
  input  wire        clr_i,     // clear latched events
  input  wire [2:0]  part_i,    // part selector
  input  wire [15:0] wdata_i,   // write data
  output reg  [15:0] rdata_o,   // selected part, combinational
  output wire        sum_o      // group summary bit
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  reg  [15:0] prev_reg;
  reg  [15:0] rise_reg;
  reg  [15:0] fall_reg;
  reg  [15:0] evt_reg;
  reg  [15:0] mask_reg;
  wire [15:0] cond_live;
  wire [15:0] evt_hit;
  wire        evt_rd;

  // top bit forced low so unsigned-unaware controllers stay happy
  assign cond_live = {1'b0, cond_i};

  // per-bit transition detection, index shared by all parts
  genvar i;
  generate
    for (i = 0; i < `SEHY_MSB; i = i + 1) begin : g_bit
      assign evt_hit[i] = (cond_live[i] & ~prev_reg[i] & rise_reg[i]) |
                          (~cond_live[i] & prev_reg[i] & fall_reg[i]);
    end
  endgenerate
  assign evt_hit[`SEHY_MSB] = 1'b0;

  assign evt_rd = rd_i & (part_i == `SEHY_PART_EVT);

  // filters, mask and latched events
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_reg <= `SEHY_ZERO16;
      rise_reg <= `SEHY_RISE_RST;
      fall_reg <= `SEHY_FALL_RST;
      evt_reg  <= `SEHY_ZERO16;
      mask_reg <= `SEHY_MASK_RST;
    end else begin
      prev_reg <= cond_live;
      if (wr_i && part_i == `SEHY_PART_RISE) begin
        rise_reg <= wdata_i & `SEHY_VALID;
      end
      if (wr_i && part_i == `SEHY_PART_FALL) begin
        fall_reg <= wdata_i & `SEHY_VALID;
      end
      if (wr_i && part_i == `SEHY_PART_MASK) begin
        mask_reg <= wdata_i & `SEHY_VALID;
      end
      // a new event in the read cycle survives the clear
      if (evt_rd || clr_i) begin
        evt_reg <= evt_hit;
      end else begin
        evt_reg <= evt_reg | evt_hit;
      end
    end
  end

  // read mux, only the latched part has a read side effect
  always @* begin
    case (part_i)
      `SEHY_PART_COND: rdata_o = cond_live;
      `SEHY_PART_RISE: rdata_o = rise_reg;
      `SEHY_PART_FALL: rdata_o = fall_reg;
      `SEHY_PART_EVT:  rdata_o = evt_reg;
      `SEHY_PART_MASK: rdata_o = mask_reg;
      default:         rdata_o = `SEHY_ZERO16;
    endcase
  end

  // masked events or-ed into the summary
  assign sum_o = |(evt_reg & mask_reg);

endmodule
`default_nettype wire

// ==== logic/sehy_top.v ====
// status event hierarchy: three scpi groups, standard event register,
// summary status byte with service request mask and request pulse
// assumes the controller's status commands arrive as one-cycle strobes
// on the command port, synchronous to sys_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "sehy_defs.vh"

module sehy_top (
  input  wire        sys_clk_i,     // system clock, 200 MHz
  input  wire        arst_n_i,      // async reset, active low
  input  wire [14:0] oper_cond_i,   // operation conditions
  input  wire [14:0] ques_cond_i,   // questionable conditions
  input  wire [14:0] dev_cond_i,    // device status conditions
  input  wire [7:0]  std_evt_i,     // standard event pulses
  input  wire        errq_nempty_i, // error queue holds an entry
  input  wire        mav_i,         // output message available
  input  wire        cmd_valid_i,   // command strobe
  input  wire        cmd_write_i,   // 1 write, 0 read
  input  wire [3:0]  cmd_target_i,  // register target
  input  wire [2:0]  cmd_part_i,    // part inside a group
  input  wire [15:0] cmd_wdata_i,   // write data
  output wire        rsp_valid_o,   // read answer strobe
  output wire [15:0] rsp_data_o,    // read answer data
  output wire [7:0]  stb_o,         // summary status byte
  output wire        srq_o          // service request pulse
);

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  wire        cmd_rd;
  wire        cmd_wr;
  wire        cls;
  wire [2:0]  grp_wr;
  wire [2:0]  grp_rd;
  wire [15:0] oper_rdata;
  wire [15:0] ques_rdata;
  wire [15:0] dev_rdata;
  wire        oper_sum;
  wire        ques_sum;
  wire        dev_sum;

  // strobes split by target so only one group sees a read or write; the clear goes to all three
  assign cmd_rd = cmd_valid_i & ~cmd_write_i;
  assign cmd_wr = cmd_valid_i & cmd_write_i;
  assign cls    = cmd_wr & (cmd_target_i == `SEHY_TGT_CLS);
  assign grp_wr[0] = cmd_wr & (cmd_target_i == `SEHY_TGT_OPER);
  assign grp_wr[1] = cmd_wr & (cmd_target_i == `SEHY_TGT_QUES);
  assign grp_wr[2] = cmd_wr & (cmd_target_i == `SEHY_TGT_DEV);
  assign grp_rd[0] = cmd_rd & (cmd_target_i == `SEHY_TGT_OPER);
  assign grp_rd[1] = cmd_rd & (cmd_target_i == `SEHY_TGT_QUES);
  assign grp_rd[2] = cmd_rd & (cmd_target_i == `SEHY_TGT_DEV);

  // ------------------------------------------------------------------
  // scpi groups
  // ------------------------------------------------------------------
  // operation group, summary into status byte bit 7
  sehy_group u_oper (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .cond_i    (oper_cond_i),
    .wr_i      (grp_wr[0]),
    .rd_i      (grp_rd[0]),
    .clr_i     (cls),
    .part_i    (cmd_part_i),
    .wdata_i   (cmd_wdata_i),
    .rdata_o   (oper_rdata),
    .sum_o     (oper_sum)
  );

  // questionable group, summary into status byte bit 3
  sehy_group u_ques (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .cond_i    (ques_cond_i),
    .wr_i      (grp_wr[1]),
    .rd_i      (grp_rd[1]),
    .clr_i     (cls),
    .part_i    (cmd_part_i),
    .wdata_i   (cmd_wdata_i),
    .rdata_o   (ques_rdata),
    .sum_o     (ques_sum)
  );

  // device status group, summary into status byte bit 1
  sehy_group u_dev (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .cond_i    (dev_cond_i),
    .wr_i      (grp_wr[2]),
    .rd_i      (grp_rd[2]),
    .clr_i     (cls),
    .part_i    (cmd_part_i),
    .wdata_i   (cmd_wdata_i),
    .rdata_o   (dev_rdata),
    .sum_o     (dev_sum)
  );

  // ------------------------------------------------------------------
  // standard event register and its mask
  // ------------------------------------------------------------------
  reg  [7:0] sevt_reg;
  reg  [7:0] sevt_next;
  reg  [7:0] sevt_mask_reg;
  wire       sevt_rd;
  wire       esb;

  assign sevt_rd = cmd_rd & (cmd_target_i == `SEHY_TGT_SEVT) &
                   (cmd_part_i == `SEHY_PART_EVT);

  // pulse in the read cycle is kept, set beats clear
  always @* begin
    if (sevt_rd || cls) begin
      sevt_next = std_evt_i;
    end else begin
      sevt_next = sevt_reg | std_evt_i;
    end
  end

  // event byte and its mask
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sevt_reg      <= `SEHY_ZERO8;
      sevt_mask_reg <= `SEHY_SEVM_RST;
    end else begin
      sevt_reg <= sevt_next;
      if (cmd_wr && cmd_target_i == `SEHY_TGT_SEVT &&
          cmd_part_i == `SEHY_PART_MASK) begin
        sevt_mask_reg <= cmd_wdata_i[7:0];
      end
    end
  end

  assign esb = |(sevt_reg & sevt_mask_reg);

  // ------------------------------------------------------------------
  // summary status byte and service request mask
  // ------------------------------------------------------------------
  reg  [7:0] srq_mask_reg;
  reg  [7:0] stb_reg;
  reg  [7:0] stb_next;
  reg  [7:0] stb_low;
  reg        srq_reg;
  wire [7:0] stb_rise;

  // gather summaries; bit 6 computed from the others
  always @* begin
    stb_low                   = `SEHY_ZERO8;
    stb_low[`SEHY_STB_DEV]    = dev_sum;
    stb_low[`SEHY_STB_ERRQ]   = errq_nempty_i;
    stb_low[`SEHY_STB_QUES]   = ques_sum;
    stb_low[`SEHY_STB_MAV]    = mav_i;
    stb_low[`SEHY_STB_ESB]    = esb;
    stb_low[`SEHY_STB_OPER]   = oper_sum;
    stb_next                  = stb_low;
    stb_next[`SEHY_STB_MSS]   = |(stb_low & srq_mask_reg &
                                  `SEHY_SRQM_KEEP);
  end

  // masked zero to one transitions of the byte, bit 6 excluded
  assign stb_rise = stb_next & ~stb_reg & srq_mask_reg &
                    `SEHY_SRQM_KEEP;

  // status byte register, mask and request pulse
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      srq_mask_reg <= `SEHY_SRQM_RST;
      stb_reg <= `SEHY_ZERO8;
      srq_reg <= 1'b0;
    end else begin
      stb_reg <= stb_next;
      srq_reg <= |stb_rise;
      if (cmd_wr && cmd_target_i == `SEHY_TGT_SRQM) begin
        srq_mask_reg <= cmd_wdata_i[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // read answers
  // ------------------------------------------------------------------
  reg        rsp_valid_reg;
  reg [15:0] rsp_data_reg;
  reg [15:0] rsp_data_next;

  // answer mux; unknown targets and parts read as zero
  always @* begin
    rsp_data_next = `SEHY_ZERO16;
    case (cmd_target_i)
      `SEHY_TGT_OPER: rsp_data_next = oper_rdata;
      `SEHY_TGT_QUES: rsp_data_next = ques_rdata;
      `SEHY_TGT_DEV:  rsp_data_next = dev_rdata;
      `SEHY_TGT_SEVT: begin
        if (cmd_part_i == `SEHY_PART_EVT) begin
          rsp_data_next = {`SEHY_ZERO8, sevt_reg};
        end else if (cmd_part_i == `SEHY_PART_MASK) begin
          rsp_data_next = {`SEHY_ZERO8, sevt_mask_reg};
        end else begin
          rsp_data_next = `SEHY_ZERO16;
        end
      end
      `SEHY_TGT_STB:  rsp_data_next = {`SEHY_ZERO8, stb_reg};
      `SEHY_TGT_SRQM: rsp_data_next = {`SEHY_ZERO8, srq_mask_reg};
      default:        rsp_data_next = `SEHY_ZERO16;
    endcase
  end

  // answer registered one cycle after the read strobe
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= `SEHY_ZERO16;
    end else begin
      rsp_valid_reg <= cmd_rd;
      if (cmd_rd) begin
        rsp_data_reg <= rsp_data_next;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o  = rsp_data_reg;
  assign stb_o       = stb_reg;
  assign srq_o       = srq_reg;

endmodule
`default_nettype wire

// ==== dv/sehy_top_asserts.sv ====
// port-level checker for the status event hierarchy top module
// assumes one clock domain and a bind onto every sehy_top instance
`timescale 1ns/100ps
`default_nettype none

module sehy_top_asserts (
  input wire logic        sys_clk_i,     // system clock
  input wire logic        arst_n_i,      // async reset, low
  input wire logic [14:0] oper_cond_i,   // operation live
  input wire logic [14:0] ques_cond_i,   // questionable live
  input wire logic [14:0] dev_cond_i,    // device live
  input wire logic [7:0]  std_evt_i,     // standard events
  input wire logic        errq_nempty_i, // error queue level
  input wire logic        mav_i,         // message available
  input wire logic        cmd_valid_i,   // command strobe
  input wire logic        cmd_write_i,   // write select
  input wire logic [3:0]  cmd_target_i,  // target
  input wire logic [2:0]  cmd_part_i,    // part
  input wire logic [15:0] cmd_wdata_i,   // write data
  input wire logic        rsp_valid_o,   // answer strobe
  input wire logic [15:0] rsp_data_o,    // answer data
  input wire logic [7:0]  stb_o,         // status byte
  input wire logic        srq_o          // service request
);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  // live part of the addressed group, so $past sees one signal
  logic [14:0] live_sel;
  assign live_sel = (cmd_target_i == 4'h0) ? oper_cond_i :
                    (cmd_target_i == 4'h1) ? ques_cond_i : dev_cond_i;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_read_answer:
    assert property (cmd_valid_i && !cmd_write_i |=> rsp_valid_o)
    else $error("read not answered");
  a_answer_cause:
    assert property (rsp_valid_o |-> $past(cmd_valid_i && !cmd_write_i))
    else $error("answer without a read");
  a_data_holds:
    assert property (!rsp_valid_o |-> $stable(rsp_data_o))
    else $error("answer data moved");
  a_top_bit_zero:
    assert property (rsp_valid_o |-> !rsp_data_o[15])
    else $error("bit 15 read as one");
  a_live_follows:
    assert property (cmd_valid_i && !cmd_write_i && cmd_part_i == 3'h0
      && cmd_target_i < 4'h3 |=> rsp_data_o == {1'b0, $past(live_sel)})
    else $error("live part differs from hardware");
  a_level_bits:
    assert property ($past(arst_n_i) |-> {stb_o[4], stb_o[2], stb_o[0]}
      == {$past(mav_i), $past(errq_nempty_i), 1'b0})
    else $error("status byte level bits wrong");
  a_mss_needs_bit:
    assert property (!(|(stb_o & 8'hBF)) |-> !stb_o[6])
    else $error("master summary without a source");
  a_srq_has_rise:
    assert property (srq_o |-> |(stb_o & ~$past(stb_o) & 8'hBF) && stb_o[6])
    else $error("request without a rising bit");
  a_reset_quiet:
    assert property (!$past(arst_n_i) |-> !srq_o && !rsp_valid_o
      && stb_o == 8'h00)
    else $error("activity right after reset");
endmodule

bind sehy_top sehy_top_asserts u_chk (.*);
`default_nettype wire

// ==== dv/sehy_ctl_model.sv ====
// remote controller model issuing status commands on the command port
// assumes the answer is registered on the taking edge itself
`timescale 1ns/100ps
`default_nettype none

module sehy_ctl_model (
  input  wire logic        sys_clk_i,    // system clock
  input  wire logic        rsp_valid_i,  // answer strobe
  input  wire logic [15:0] rsp_data_i,   // answer data
  output var  logic        cmd_valid_o,  // command strobe
  output var  logic        cmd_write_o,  // write select
  output var  logic [3:0]  cmd_target_o, // target
  output var  logic [2:0]  cmd_part_o,   // part
  output var  logic [15:0] cmd_wdata_o   // write data
);
  // ------------------------------------------------------------
  // command issue
  // ------------------------------------------------------------
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_target_o = 4'hF;
    cmd_part_o = 3'h7;
    cmd_wdata_o = 16'hA5A5;
  end

  // released lines wander so a stale value is never mistaken for data
  task automatic issue(input logic w, input logic [3:0] t,
                       input logic [2:0] p, input logic [15:0] dat);
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_target_o = t;
    cmd_part_o = p;
    cmd_wdata_o = dat;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_write_o = ~w;
    cmd_target_o = ~t;
    cmd_part_o = ~p;
    cmd_wdata_o = ~dat;
  endtask

  task automatic wr(input logic [3:0] t, input logic [2:0] p,
                    input logic [15:0] dat);
    issue(1'b1, t, p, dat);
  endtask

  // answer stands one cycle, so it is taken right after the edge
  task automatic rd(input logic [3:0] t, input logic [2:0] p,
                    output logic v, output logic [15:0] dat);
    issue(1'b0, t, p, 16'h0000);
    v = rsp_valid_i;
    dat = rsp_data_i;
  endtask
endmodule
`default_nettype wire

// ==== dv/status_event_hierarchy_bench.sv ====
// self-checking bench for the status event hierarchy top module
// assumes sehy_defs.vh on the include path and the controller model
`timescale 1ns/100ps
`default_nettype none
`include "sehy_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end

module status_event_hierarchy_bench;
  logic        sys_clk_i, arst_n_i, errq_nempty_i, mav_i, v;
  logic        cmd_valid_i, cmd_write_i, rsp_valid_o, srq_o;
  logic [14:0] cond [3];
  logic [7:0]  std_evt_i, stb_o;
  logic [3:0]  cmd_target_i;
  logic [2:0]  cmd_part_i;
  logic [15:0] cmd_wdata_i, rsp_data_o, d;
  int          error_cnt, n_tests, srq_n;
  int          pos [3] = '{`SEHY_STB_OPER, `SEHY_STB_QUES, `SEHY_STB_DEV};
  int          prt [3] = '{1, 2, 4};

  // ------------------------------------------------------------
  // instances, clock, helpers
  // ------------------------------------------------------------
  sehy_top u_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .oper_cond_i(cond[0]), .ques_cond_i(cond[1]), .dev_cond_i(cond[2]),
    .std_evt_i(std_evt_i), .errq_nempty_i(errq_nempty_i), .mav_i(mav_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
    .cmd_target_i(cmd_target_i), .cmd_part_i(cmd_part_i),
    .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .stb_o(stb_o), .srq_o(srq_o));
  sehy_ctl_model u_ctl (.sys_clk_i(sys_clk_i), .rsp_valid_i(rsp_valid_o),
    .rsp_data_i(rsp_data_o), .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_target_o(cmd_target_i),
    .cmd_part_o(cmd_part_i), .cmd_wdata_o(cmd_wdata_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // request is a one-cycle pulse, so count them rather than poll
  always @(posedge sys_clk_i) if (srq_o === 1'b1) srq_n++;

  task automatic rdc(input int t, input int p, input logic [15:0] e);
    u_ctl.rd(t[3:0], p[2:0], v, d);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask
  task automatic wrc(input int t, input int p, input logic [15:0] x);
    u_ctl.wr(t[3:0], p[2:0], x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run is under three hundred cycles; this is ample
  initial begin
    #100000;
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report;
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    arst_n_i = 1'b0;
    cond = '{15'h0000, 15'h0000, 15'h0000};
    std_evt_i = 8'h00;
    errq_nempty_i = 1'b0;
    mav_i = 1'b0;
    idle(8);
    arst_n_i = 1'b1;
    for (int g = 0; g < 3; g++) begin
      rdc(g, 1, `SEHY_RISE_RST);
      rdc(g, 2, `SEHY_FALL_RST);
      rdc(g, 3, `SEHY_ZERO16);
      rdc(g, 4, `SEHY_MASK_RST);
    end
    rdc(5, 0, 16'h0000);
    rdc(7, 0, 16'h0000);
    $display("test defaults done");
    for (int g = 0; g < 3; g++) begin
      for (int i = 0; i < 3; i++) begin
        wrc(g, prt[i], 16'hFFFF);
        rdc(g, prt[i], `SEHY_VALID);
        wrc(g, prt[i], 16'h5A5A);
        rdc(g, prt[i], 16'h5A5A);
      end
      wrc(g, 0, 16'h1234);
      rdc(g, 0, 16'h0000);
      wrc(g, 3, 16'h00FF);
      rdc(g, 3, 16'h0000);
    end
    $display("test access done");
    for (int g = 0; g < 3; g++) begin
      wrc(g, 1, 16'h0003);
      wrc(g, 2, 16'h000C);
      cond[g] = 15'h000F;
      rdc(g, 0, 16'h000F);
      rdc(g, 0, 16'h000F);
      idle(5);
      rdc(g, 3, 16'h0003);
      rdc(g, 3, 16'h0000);
      cond[g] = 15'h0000;
      rdc(g, 3, 16'h000C);
    end
    $display("test transitions done");
    for (int g = 0; g < 3; g++) begin
      wrc(4'h5, 0, 16'h0040 | (16'h0001 << pos[g]));
      wrc(g, 4, 16'h0000);
      srq_n = 0;
      cond[g] = 15'h0001;
      idle(3);
      `CHK(stb_o[pos[g]], 1'b0)
      wrc(g, 4, 16'h0001);
      idle(2);
      `CHK(stb_o[pos[g]], 1'b1)
      `CHK(stb_o[6], 1'b1)
      `CHK(srq_n, 1)
      rdc(g, 3, 16'h0001);
      idle(2);
      `CHK(stb_o, 8'h00)
      cond[g] = 15'h0000;
    end
    $display("test summary done");
    wrc(5, 0, 16'h0040);
    srq_n = 0;
    errq_nempty_i = 1'b1;
    idle(3);
    `CHK(stb_o, 8'h04)
    `CHK(srq_n, 0)
    wrc(5, 0, 16'h0004);
    errq_nempty_i = 1'b0;
    idle(2);
    errq_nempty_i = 1'b1;
    idle(3);
    `CHK(stb_o, 8'h44)
    `CHK(srq_n, 1)
    errq_nempty_i = 1'b0;
    mav_i = 1'b1;
    idle(2);
    `CHK(stb_o, 8'h10)
    mav_i = 1'b0;
    wrc(3, 4, 16'h0001);
    std_evt_i = 8'h01;
    idle(1);
    std_evt_i = 8'h00;
    idle(2);
    `CHK(stb_o[5], 1'b1)
    rdc(3, 3, 16'h0001);
    rdc(3, 3, 16'h0000);
    $display("test status byte done");
    cond[0] = 15'h0002;
    idle(2);
    wrc(6, 0, 16'h0000);
    rdc(0, 3, 16'h0000);
    arst_n_i = 1'b0;
    idle(8);
    arst_n_i = 1'b1;
    rdc(0, 1, `SEHY_RISE_RST);
    rdc(0, 4, `SEHY_MASK_RST);
    `CHK(stb_o, 8'h00)
    $display("test reset done");
    final_report;
  end
endmodule
`default_nettype wire
